// ==== logic/timer_map.svh ====
// constants for the interval timer channel
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define RL_LATCH 2'h0
`define RL_LSB 2'h1
`define RL_MSB 2'h2
`define RL_BOTH 2'h3
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_RL_HI 5
`define CW_RL_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0
`define SEL_CTRL 2'h3
`define COUNT_RESET 16'h0000
`endif

// ==== logic/timer_pkg.sv ====
// types for the interval timer
package timer_pkg;
    typedef enum logic [2:0] {
        MODE_TC = 3'b000,
        MODE_ONESHOT = 3'b001,
        MODE_RATE = 3'b010,
        MODE_SQUARE = 3'b011,
        MODE_SWSTROBE = 3'b100,
        MODE_HWSTROBE = 3'b101
    } mode_t;
    typedef logic [15:0] count_t;
endpackage

// ==== logic/count_if.sv ====
// carrier between channel and its counter core
`timescale 1ns/1ps
interface count_if;
    logic load;
    logic [15:0] value;
    logic [2:0] mode;
    logic gate;
    logic tick;
    logic [15:0] count;
    logic out;
    modport ctrl(output load, value, mode, gate, tick, input count, out);
    modport core(input load, value, mode, gate, tick, output count, out);
endinterface

// ==== logic/count_core.sv ====
// down counter core with gate behaviour per mode
`timescale 1ns/1ps
`include "timer_map.svh"
module count_core (
    input wire logic clk,
    input wire logic rst,
    count_if.core cif
);
    import timer_pkg::*;
    logic [15:0] count;
    logic [15:0] reload;
    logic running;
    logic out;
    logic gate_d;
    logic armed;
    wire gate_rise = cif.gate & ~gate_d;
    wire square = (cif.mode[1:0] == 2'b11);
    wire rate = (cif.mode[1:0] == 2'b10);
    wire trig_mode = (cif.mode == 3'b001) || (cif.mode == 3'b101);
    wire [15:0] step = square ? 16'h0002 : 16'h0001;
    wire [15:0] dec = count - step;
    wire gate_ok = trig_mode | cif.gate;
    wire at_end = (count == step);
    assign cif.count = count;
    assign cif.out = out;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
            reload <= 16'h0000;
            running <= 1'b0;
            out <= 1'b1;
            gate_d <= 1'b0;
            armed <= 1'b0;
        end else begin
            gate_d <= cif.gate;
            if (cif.load) begin
                reload <= cif.value;
                count <= cif.value;
                armed <= 1'b1;
                running <= !trig_mode;
                out <= (cif.mode != 3'b000);
            end else if (armed && trig_mode && gate_rise) begin
                count <= reload; // [R1]
                running <= 1'b1; // [R1]
                out <= (cif.mode != 3'b001) | out & 1'b0; // [R12]
            end else if (armed && (rate | square | cif.mode == 3'b100) && gate_rise) begin
                count <= reload; // [R2] [R11]
                running <= 1'b1;
                out <= 1'b1;
            end else if ((rate | square) && !cif.gate) begin
                out <= 1'b1; // [R3]
            end else if (running && gate_ok && cif.tick) begin
                count <= dec; // [R4] [R10]
                if (at_end) begin
                    count <= reload;
                    case (cif.mode)
                        3'b000: begin out <= 1'b1; running <= 1'b0; end
                        3'b001: begin out <= 1'b1; running <= 1'b0; end // [R12]
                        3'b010: out <= 1'b1;
                        3'b011: out <= ~out;
                        default: begin out <= 1'b1; running <= 1'b0; end
                    endcase
                end else if (rate && dec == 16'h0001) begin
                    out <= 1'b0;
                end else if ((cif.mode[2] && !cif.mode[1]) && dec == 16'h0001) begin
                    out <= 1'b0;
                end else if (cif.mode == 3'b100 || cif.mode == 3'b101) begin
                    out <= 1'b1;
                end
            end
        end
    end
    a_gate_forces_high: assert property (@(posedge clk) disable iff (rst)
        ((rate | square) && !cif.gate && !cif.load) |=> out) // [R3]
        else $error("output not high while gate low");
    a_oneshot_low: assert property (@(posedge clk) disable iff (rst)
        (armed && cif.mode == 3'b001 && gate_rise && !cif.load) |=> !out) // [R12]
        else $error("one-shot output not low after trigger");
    a_trigger_reload: assert property (@(posedge clk) disable iff (rst)
        (armed && trig_mode && gate_rise && !cif.load) |=> (count == $past(reload) && running)) // [R1]
        else $error("trigger did not reload");
    a_gate_hold: assert property (@(posedge clk) disable iff (rst)
        (cif.mode == 3'b000 && !cif.gate && !gate_d && !cif.load) |=> $stable(count)) // [R10]
        else $error("mode 0 count moved with gate low");
    a_square_step: assert property (@(posedge clk) disable iff (rst)
        (square && running && cif.gate && gate_d && cif.tick && !cif.load && count > 16'h0002)
        |=> count == $past(count) - 16'h0002) // [R4]
        else $error("square mode step not two");
endmodule

// ==== logic/timer_channel.sv ====
// one timer channel: gate handling, direct read and latched read
`timescale 1ns/1ps
`include "timer_map.svh"
// Contract
// R1: modes 1,5 gate rise starts or retriggers
// R2: modes 2,3 gate low inhibits, rise restarts
// R3: modes 2,3 gate low forces output high
// R4: count down; square mode steps by two
// R5: count readable while counting runs
// R6: direct read returns live count
// R7: host halts counter before direct read
// R8: latch command snapshots count undisturbed
// R9: host may cascade two counters
// R10: mode 0 gate low suspends, resumes
// R11: mode 4 gate rise restarts from load
// R12: mode 1 output low until terminal
// R13: snapshot frozen until fully read
module timer_channel (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CNT_CLK,
    input wire logic GATE,
    input wire logic WR_CTRL,
    input wire logic WR_DATA,
    input wire logic RD_DATA,
    input wire logic [7:0] DIN,
    output logic [7:0] DOUT,
    output logic OUT,
    output timer_pkg::count_t COUNT_VIEW
);
    import timer_pkg::*;
    count_if cif();
    logic clk_s1, clk_s2, clk_s3;
    logic gate_s1, gate_s2;
    logic [1:0] rl;
    logic [2:0] mode;
    logic [7:0] lsb;
    logic low_next;
    logic rd_hi;
    logic latched;
    logic [15:0] snap;
    logic load;
    logic [15:0] value;
    wire own_cmd = WR_CTRL && DIN[`CW_SEL_HI:`CW_SEL_LO] != `SEL_CTRL;
    wire latch_cmd = own_cmd && DIN[`CW_RL_HI:`CW_RL_LO] == `RL_LATCH;
    wire [15:0] rd_src = latched ? snap : cif.count;
    wire [7:0] rd_byte = (rl == `RL_MSB || (rl == `RL_BOTH && rd_hi)) ? rd_src[15:8] : rd_src[7:0];
    wire last_byte = (rl != `RL_BOTH) || rd_hi;
    assign cif.load = load;
    assign cif.value = value;
    assign cif.mode = mode;
    assign cif.gate = gate_s2;
    assign cif.tick = clk_s2 & ~clk_s3;
    count_core u_core (
        .clk(REF_CLK),
        .rst(RST),
        .cif(cif)
    );
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            gate_s1 <= 1'b0;
            gate_s2 <= 1'b0;
        end else begin
            clk_s1 <= CNT_CLK;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            gate_s1 <= GATE;
            gate_s2 <= gate_s1;
        end
    end
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rl <= `RL_BOTH;
            mode <= 3'b000;
            lsb <= 8'h00;
            low_next <= 1'b1;
            load <= 1'b0;
            value <= `COUNT_RESET;
        end else begin
            load <= 1'b0;
            if (own_cmd && !latch_cmd) begin
                rl <= DIN[`CW_RL_HI:`CW_RL_LO];
                mode <= (DIN[2:1] == 2'b11 || DIN[2:1] == 2'b10) ? {1'b0, DIN[2:1]} : DIN[3:1];
                low_next <= 1'b1;
            end else if (WR_DATA) begin
                if (rl == `RL_LSB) begin
                    value <= {8'h00, DIN};
                    load <= 1'b1;
                end else if (rl == `RL_MSB) begin
                    value <= {DIN, 8'h00};
                    load <= 1'b1;
                end else if (low_next) begin
                    lsb <= DIN;
                    low_next <= 1'b0;
                end else begin
                    value <= {DIN, lsb};
                    load <= 1'b1;
                    low_next <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            latched <= 1'b0;
            snap <= `COUNT_RESET;
            rd_hi <= 1'b0;
            DOUT <= 8'h00;
        end else begin
            if (latch_cmd && !latched) begin
                latched <= 1'b1; // [R8] [R13]
                snap <= cif.count; // [R8]
            end
            if (own_cmd && !latch_cmd) begin
                rd_hi <= 1'b0;
            end else if (RD_DATA) begin
                DOUT <= rd_byte; // [R5] [R6]
                rd_hi <= (rl == `RL_BOTH) ? ~rd_hi : 1'b0;
                // a latch landing with a live read must not be cleared at once
                if (last_byte && latched) begin
                    latched <= 1'b0; // [R13]
                end
            end
        end
    end
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            OUT <= 1'b1;
            COUNT_VIEW <= `COUNT_RESET;
        end else begin
            OUT <= cif.out;
            COUNT_VIEW <= cif.count;
        end
    end
    a_snap_frozen: assert property (@(posedge REF_CLK) disable iff (RST)
        (latched && !(RD_DATA && last_byte)) |=> (latched && $stable(snap))) // [R13]
        else $error("snapshot changed before full read");
    a_latch_capture: assert property (@(posedge REF_CLK) disable iff (RST)
        (latch_cmd && !latched) |=> (latched && snap == $past(cif.count))) // [R8]
        else $error("latch did not capture count");
    a_live_read: assert property (@(posedge REF_CLK) disable iff (RST)
        (RD_DATA && !latched && !rd_hi && rl != `RL_MSB && !own_cmd) |=> DOUT == $past(cif.count[7:0])) // [R6]
        else $error("direct read not live count");
endmodule

// ==== verification/host_model.sv ====
// host side model: control, count and read strobes of one channel
`timescale 1ns/1ps
module host_model (
    input wire logic REF_CLK,
    input wire logic [7:0] DOUT,
    output logic WR_CTRL,
    output logic WR_DATA,
    output logic RD_DATA,
    output logic [7:0] DIN
);
    initial begin
        WR_CTRL = 1'h0;
        WR_DATA = 1'h0;
        RD_DATA = 1'h0;
        DIN = 8'h00;
    end
    task automatic put(input logic ctrl, input logic [7:0] b);
        @(posedge REF_CLK);
        WR_CTRL <= ctrl;
        WR_DATA <= !ctrl;
        DIN <= b;
        @(posedge REF_CLK);
        WR_CTRL <= 1'h0;
        WR_DATA <= 1'h0;
        DIN <= ~b; // idle bus must not look like the last byte
    endtask
    task automatic get(output logic [7:0] b);
        @(posedge REF_CLK);
        RD_DATA <= 1'h1;
        @(posedge REF_CLK);
        RD_DATA <= 1'h0;
        @(posedge REF_CLK);
        #1 b = DOUT;
    endtask
endmodule

// ==== verification/counter_gate_and_readback_bench.sv ====
// bench for one timer channel: gate per mode, direct and latched reads
`timescale 1ns/1ps
`include "timer_map.svh"
module counter_gate_and_readback_bench;
    import timer_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic cnt_clk = 1'h0;
    logic gate = 1'h0;
    logic wr_ctrl, wr_data, rd_data, out_lvl;
    logic [7:0] din, dout, lo, hi;
    logic [31:0] seed = 32'h00012455;
    count_t view, n, c, step;
    count_t n_low = 16'h0000;
    logic out_q = 1'h1;
    mode_t m;
    int n_fail = 0;
    int n_compared = 0;
    always #4 ref_clk = ~ref_clk;
    // upper half of a cascade: counts the low pulses of a rate-mode channel
    always @(posedge ref_clk) begin
        out_q <= out_lvl;
        if (out_q && !out_lvl) n_low <= n_low + 16'h0001;
    end
    host_model host (.REF_CLK(ref_clk), .DOUT(dout), .WR_CTRL(wr_ctrl), .WR_DATA(wr_data),
        .RD_DATA(rd_data), .DIN(din));
    timer_channel DUT (.REF_CLK(ref_clk), .RST(rst), .CNT_CLK(cnt_clk), .GATE(gate), .WR_CTRL(wr_ctrl),
        .WR_DATA(wr_data), .RD_DATA(rd_data), .DIN(din), .DOUT(dout), .OUT(out_lvl), .COUNT_VIEW(view));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] cw(input mode_t md, input logic [1:0] rl);
        return {2'h0, rl, md, 1'h0};
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // slow counter clock; the pin is synchronised, so leave it time to land
    task automatic tick();
        @(posedge ref_clk);
        cnt_clk <= 1'h1;
        cyc(4);
        cnt_clk <= 1'h0;
        cyc(4);
    endtask
    task automatic set_gate(input logic v);
        @(posedge ref_clk);
        gate <= v;
        cyc(5);
    endtask
    task automatic load(input mode_t md, input count_t v);
        host.put(1'h1, cw(md, `RL_BOTH));
        host.put(1'h0, v[7:0]);
        host.put(1'h0, v[15:8]);
        cyc(4);
    endtask
    task automatic read16(output count_t v);
        host.get(lo);
        host.get(hi);
        v = {hi, lo};
    endtask
    task automatic chk16(input count_t got, input count_t exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t count %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t level %b want %b", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        n_fail++;
        wrap_up();
    end
    initial begin
        cyc(5);
        rst <= 1'h0;
        seed = xs(seed);
        n = {8'h40, seed[7:0]};
        set_gate(1'h1);
        load(MODE_TC, n);
        repeat (3) tick();
        chk16(view, n - 16'h0003);
        set_gate(1'h0);
        repeat (2) tick();
        chk16(view, n - 16'h0003);
        read16(c); // gate held low first
        chk16(c, n - 16'h0003);
        set_gate(1'h1);
        host.put(1'h1, cw(MODE_TC, `RL_LATCH));
        repeat (2) tick();
        host.put(1'h1, cw(MODE_TC, `RL_LATCH));
        chk16(view, n - 16'h0005);
        read16(c);
        chk16(c, n - 16'h0003);
        read16(c);
        chk16(c, n - 16'h0005);
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            n = {8'h20, seed[7:1], 1'h0};
            m = i ? MODE_SQUARE : MODE_RATE;
            step = i ? 16'h0002 : 16'h0001;
            load(m, n);
            repeat (2) tick();
            c = view;
            tick();
            chk16(view, c - step);
            set_gate(1'h0);
            chk1(out_lvl, 1'h1);
            c = view;
            tick();
            chk16(view, c);
            set_gate(1'h1);
            tick();
            chk1((view === n) || (view === n - step), 1'h1);
        end
        // mode 4 shares the restart check: gate rise brings back the load
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? MODE_ONESHOT : (i == 1) ? MODE_HWSTROBE : MODE_SWSTROBE;
            set_gate(1'h0);
            load(m, 16'h0100);
            set_gate(1'h1);
            repeat (3) tick();
            if (i == 0) chk1(out_lvl, 1'h0);
            set_gate(1'h0);
            set_gate(1'h1);
            tick();
            chk1((view === 16'h0100) || (view === 16'h00FF), 1'h1);
        end
        c = n_low;
        load(MODE_RATE, 16'h0003);
        repeat (6) tick();
        chk16(n_low - c, 16'h0002);
        wrap_up();
    end
endmodule
